// ==== rtl/tmc_consts.svh ====
// register map, field positions, reset values and rule summary of the timer block
//
// Contract
// - the 16-bit counter counts up from zero to all ones and wraps
// - overflow sets a sticky overflow flag until software clears it
// - overflow request output is raised only while its enable bit is set
// - special event compare match of the second unit resets the counter
// - special event also starts a conversion when the converter is enabled
// - special event reset is not promised in asynchronous counter mode
// - software counter write in the trigger cycle wins over the reset
// - special event reset never sets the overflow flag
// - each unit holds one 16-bit data register for capture, compare or duty
// - mode register bits 7 and 6 read as zero
// - mode bits 5-4 are the low duty bits; codes 11xx select pwm
// - mode code 0000 disables the unit and clears its pin and capture count; the data register keeps its value
// - mode code 0010 toggles the pin and sets the flag on match; the code sets the flag for the second unit only
// - codes 0100 to 0111 capture on fall, rise, 4th rise, 16th rise
// - codes 1000 and 1001 preset the pin then force it on match
// - code 1010 only sets the flag; pin follows the port latch; the code sets no flag for the first unit
// - code 1011 sets flag, emits special event and requests conversion; the code does this for the second unit only
// - mode register and both data halves are software readable and writable
// - clock select clear counts each instruction cycle, set counts external rises
// - prescale codes 00 to 11 divide by 1, 2, 4, 8
// - wide mode latches high byte on low read and loads it on low write
// - high byte writes keep the prescaler, low byte writes clear it
`ifndef TMC_CONSTS_SVH
`define TMC_CONSTS_SVH

// register offsets on the plain register port
`define TMC_ADDR_FLAGS     4'h0
`define TMC_ADDR_ENABLES   4'h1
`define TMC_ADDR_PRIORITY  4'h2
`define TMC_ADDR_CNT_LO    4'h3
`define TMC_ADDR_CNT_HI    4'h4
`define TMC_ADDR_COMP_CTL  4'h5
`define TMC_ADDR_CNT_CTL   4'h6
`define TMC_ADDR_U1_MODE   4'h7
`define TMC_ADDR_U1_LO     4'h8
`define TMC_ADDR_U1_HI     4'h9
`define TMC_ADDR_U2_MODE   4'ha
`define TMC_ADDR_U2_LO     4'hb
`define TMC_ADDR_U2_HI     4'hc

// field positions
`define TMC_FLAG_OVF_BIT   1
`define TMC_FLAG_U2_BIT    0
`define TMC_OSC_EN_BIT     3
`define TMC_CTL_WIDE_BIT   7
`define TMC_CTL_PS_HI      5
`define TMC_CTL_PS_LO      4
`define TMC_CTL_SYNCB_BIT  2
`define TMC_CTL_CS_BIT     1
`define TMC_CTL_ON_BIT     0
`define TMC_MODE_MASK      8'h3f

// reset values
`define TMC_RST_BYTE       8'h00
`define TMC_RST_WORD       16'h0000
`define TMC_CNT_MAX        16'hffff

// instruction cycle is four system clocks
`define TMC_INSTR_DIV      2'h3

`endif

// ==== rtl/tmc_pkg.sv ====
// types shared by the timer and match unit block
package tmc_pkg;

  typedef enum logic [3:0] {
    TMC_M_OFF      = 4'h0,
    TMC_M_RSV1     = 4'h1,
    TMC_M_TOGGLE   = 4'h2,
    TMC_M_RSV3     = 4'h3,
    TMC_M_CAP_FALL = 4'h4,
    TMC_M_CAP_RISE = 4'h5,
    TMC_M_CAP_4    = 4'h6,
    TMC_M_CAP_16   = 4'h7,
    TMC_M_SET_HI   = 4'h8,
    TMC_M_SET_LO   = 4'h9,
    TMC_M_SOFT     = 4'ha,
    TMC_M_SPECIAL  = 4'hb
  } tmc_mode_e;

  // register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tmc_bus_s;

  // one capture/compare/pwm unit
  typedef struct packed {
    logic [7:0]  mode;
    logic [15:0] data;
    logic        pin;
    logic        pin_prev;
    logic [3:0]  cap_cnt;
    logic        pin_in_prev;
    logic [3:0]  mode_prev;
  } tmc_unit_s;

  // all block state
  typedef struct packed {
    logic [7:0]  flags;
    logic [7:0]  enables;
    logic [7:0]  priority_r;
    logic [7:0]  comp_ctl;
    logic [7:0]  cnt_ctl;
    logic [15:0] cnt;
    logic [7:0]  hi_buf;
    logic [2:0]  ps_cnt;
    logic [1:0]  div_cnt;
    logic [1:0]  ext_sync;
    logic        ext_prev;
    logic [1:0]  cap1_sync;
    logic [1:0]  cap2_sync;
    tmc_unit_s   u1;
    tmc_unit_s   u2;
    logic [7:0]  rdata;
    logic        conv_start;
  } tmc_state_s;

endpackage

// ==== rtl/tmc_timer.sv ====
// 16-bit counter with the mode control of two capture/compare/pwm units
`timescale 1ns/1ps
`include "tmc_consts.svh"

module tmc_timer (
  input  wire logic             I_MCLK,
  input  wire logic             I_RSTN,
  input  wire tmc_pkg::tmc_bus_s I_BUS,
  output logic [7:0]            O_RDATA,
  input  wire logic             I_EXT_CLK,
  input  wire logic             I_CAP1_PIN,
  input  wire logic             I_CAP2_PIN,
  input  wire logic             I_PORT1_LATCH,
  input  wire logic             I_PORT2_LATCH,
  input  wire logic             I_CONV_ENABLE,
  output logic                  O_UNIT1_PIN,
  output logic                  O_UNIT2_PIN,
  output logic [9:0]            O_DUTY1,
  output logic [9:0]            O_DUTY2,
  output logic                  O_OVF_IRQ,
  output logic                  O_UNIT2_IRQ,
  output logic                  O_CONV_START
);
  import tmc_pkg::*;

  tmc_state_s r;
  tmc_state_s next_r;

  // ****************************************************************
  // helpers
  // ****************************************************************

  // prescale terminal count for the select code
  function automatic logic [2:0] ps_limit(input logic [1:0] sel);
    case (sel)
      2'h0:    ps_limit = 3'h0;
      2'h1:    ps_limit = 3'h1;
      2'h2:    ps_limit = 3'h3;
      default: ps_limit = 3'h7;
    endcase
  endfunction

  // true for the compare codes that act on a match
  function automatic logic is_compare(input logic [3:0] m);
    is_compare = (m == TMC_M_TOGGLE) || (m[3:2] == 2'h2);
  endfunction

  // capture event for the unit's mode and the synchronised pin
  function automatic logic cap_edge(input logic [3:0] m, input logic now_lv,
                                    input logic was);
    case (m)
      TMC_M_CAP_FALL: cap_edge = was && !now_lv;
      TMC_M_CAP_RISE,
      TMC_M_CAP_4,
      TMC_M_CAP_16:   cap_edge = !was && now_lv;
      default:        cap_edge = 1'b0;
    endcase
  endfunction

  // capture edge count needed for the mode, minus one
  function automatic logic [3:0] cap_need(input logic [3:0] m);
    case (m)
      TMC_M_CAP_4:  cap_need = 4'h3;
      TMC_M_CAP_16: cap_need = 4'hf;
      default:      cap_need = 4'h0;
    endcase
  endfunction

  // one unit's mode, capture and compare step
  function automatic tmc_unit_s unit_step(input tmc_unit_s u, input logic pin_lv,
                                          input logic [15:0] cnt, input logic tick,
                                          output logic match, output logic capt);
    tmc_unit_s n;
    logic [3:0] m;
    n = u;
    m = u.mode[3:0];
    match = 1'b0;
    capt = 1'b0;
    n.pin_in_prev = pin_lv;
    n.mode_prev = m;
    if (m == TMC_M_OFF || m == TMC_M_RSV1 || m == TMC_M_RSV3) begin
      n.cap_cnt = 4'h0;
      n.pin = 1'b0;
    end else if (m[3:2] == 2'h1) begin
      if (m != u.mode_prev) begin
        n.cap_cnt = 4'h0;
      end else if (cap_edge(m, pin_lv, u.pin_in_prev)) begin
        if (u.cap_cnt == cap_need(m)) begin
          n.cap_cnt = 4'h0;
          n.data = cnt;
          capt = 1'b1;
        end else begin
          n.cap_cnt = u.cap_cnt + 4'h1;
        end
      end
    end else if (is_compare(m)) begin
      if (m != u.mode_prev && m == TMC_M_SET_HI) begin
        n.pin = 1'b0;
      end else if (m != u.mode_prev && m == TMC_M_SET_LO) begin
        n.pin = 1'b1;
      end
      if (tick && cnt == u.data) begin
        match = 1'b1;
        case (m)
          TMC_M_TOGGLE: n.pin = !u.pin;
          TMC_M_SET_HI: n.pin = 1'b1;
          TMC_M_SET_LO: n.pin = 1'b0;
          default:      n.pin = u.pin;
        endcase
      end
    end
    unit_step = n;
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************

  logic        tick;
  logic        ext_rise;
  logic        instr_en;
  logic        m1;
  logic        m2;
  logic        c1;
  logic        c2;
  logic        special;
  logic        cnt_write;
  logic [3:0]  mode2;

  // count, prescale, register access and unit modes
  always_comb begin
    next_r = r;
    next_r.ext_sync = {r.ext_sync[0], I_EXT_CLK};
    next_r.cap1_sync = {r.cap1_sync[0], I_CAP1_PIN};
    next_r.cap2_sync = {r.cap2_sync[0], I_CAP2_PIN};
    next_r.ext_prev = r.ext_sync[1];
    next_r.div_cnt = r.div_cnt + 2'h1;
    next_r.conv_start = 1'b0;
    instr_en = (r.div_cnt == `TMC_INSTR_DIV);
    ext_rise = r.ext_sync[1] && !r.ext_prev;
    tick = 1'b0;
    // counter clock source and prescaler
    if (r.cnt_ctl[`TMC_CTL_ON_BIT]) begin
      if (r.cnt_ctl[`TMC_CTL_CS_BIT] ? ext_rise : instr_en) begin
        if (r.ps_cnt == ps_limit(r.cnt_ctl[`TMC_CTL_PS_HI:`TMC_CTL_PS_LO])) begin
          next_r.ps_cnt = 3'h0;
          tick = 1'b1;
        end else begin
          next_r.ps_cnt = r.ps_cnt + 3'h1;
        end
      end
    end
    // units compare against the count about to advance
    next_r.u1 = unit_step(r.u1, r.cap1_sync[1], r.cnt, tick, m1, c1);
    next_r.u2 = unit_step(r.u2, r.cap2_sync[1], r.cnt, tick, m2, c2);
    mode2 = r.u2.mode[3:0];
    special = m2 && (mode2 == TMC_M_SPECIAL);
    if (m2 || c2) begin
      next_r.flags[`TMC_FLAG_U2_BIT] = 1'b1;
    end
    if (tick) begin
      next_r.cnt = r.cnt + 16'h0001;
      if (r.cnt == `TMC_CNT_MAX) begin
        next_r.flags[`TMC_FLAG_OVF_BIT] = 1'b1;
      end
    end
    // special event resets the count without touching the overflow flag
    if (special) begin
      next_r.cnt = `TMC_RST_WORD;
      next_r.conv_start = I_CONV_ENABLE;
    end
    // software access
    cnt_write = 1'b0;
    if (I_BUS.rd) begin
      case (I_BUS.addr)
        `TMC_ADDR_FLAGS:    next_r.rdata = r.flags;
        `TMC_ADDR_ENABLES:  next_r.rdata = r.enables;
        `TMC_ADDR_PRIORITY: next_r.rdata = r.priority_r;
        `TMC_ADDR_CNT_LO: begin
          next_r.rdata = r.cnt[7:0];
          if (r.cnt_ctl[`TMC_CTL_WIDE_BIT]) begin
            next_r.hi_buf = r.cnt[15:8];
          end
        end
        `TMC_ADDR_CNT_HI: begin
          next_r.rdata = r.cnt_ctl[`TMC_CTL_WIDE_BIT] ? r.hi_buf : r.cnt[15:8];
        end
        `TMC_ADDR_COMP_CTL: next_r.rdata = r.comp_ctl;
        `TMC_ADDR_CNT_CTL:  next_r.rdata = r.cnt_ctl;
        `TMC_ADDR_U1_MODE:  next_r.rdata = r.u1.mode & `TMC_MODE_MASK;
        `TMC_ADDR_U1_LO:    next_r.rdata = r.u1.data[7:0];
        `TMC_ADDR_U1_HI:    next_r.rdata = r.u1.data[15:8];
        `TMC_ADDR_U2_MODE:  next_r.rdata = r.u2.mode & `TMC_MODE_MASK;
        `TMC_ADDR_U2_LO:    next_r.rdata = r.u2.data[7:0];
        `TMC_ADDR_U2_HI:    next_r.rdata = r.u2.data[15:8];
        default:            next_r.rdata = `TMC_RST_BYTE;
      endcase
    end else begin
      next_r.rdata = `TMC_RST_BYTE;
    end
    if (I_BUS.wr) begin
      case (I_BUS.addr)
        // clearing flags: a same-cycle hardware set wins
        `TMC_ADDR_FLAGS:    next_r.flags = I_BUS.wdata | (next_r.flags & ~r.flags);
        `TMC_ADDR_ENABLES:  next_r.enables = I_BUS.wdata;
        `TMC_ADDR_PRIORITY: next_r.priority_r = I_BUS.wdata;
        `TMC_ADDR_CNT_LO: begin
          cnt_write = 1'b1;
          next_r.cnt[7:0] = I_BUS.wdata;
          if (r.cnt_ctl[`TMC_CTL_WIDE_BIT]) begin
            next_r.cnt[15:8] = r.hi_buf;
          end else begin
            next_r.cnt[15:8] = tick ? r.cnt[15:8] + {7'h00, r.cnt[7:0] == 8'hff}
                                    : r.cnt[15:8];
            if (special) begin
              next_r.cnt[15:8] = r.cnt[15:8];
            end
          end
          next_r.ps_cnt = 3'h0;
        end
        `TMC_ADDR_CNT_HI: begin
          if (r.cnt_ctl[`TMC_CTL_WIDE_BIT]) begin
            next_r.hi_buf = I_BUS.wdata;
          end else begin
            cnt_write = 1'b1;
            next_r.cnt[15:8] = I_BUS.wdata;
            next_r.cnt[7:0] = special ? r.cnt[7:0] : next_r.cnt[7:0];
          end
        end
        `TMC_ADDR_COMP_CTL: next_r.comp_ctl = I_BUS.wdata;
        `TMC_ADDR_CNT_CTL:  next_r.cnt_ctl = I_BUS.wdata;
        `TMC_ADDR_U1_MODE:  next_r.u1.mode = I_BUS.wdata & `TMC_MODE_MASK;
        `TMC_ADDR_U1_LO:    next_r.u1.data[7:0] = I_BUS.wdata;
        `TMC_ADDR_U1_HI:    next_r.u1.data[15:8] = I_BUS.wdata;
        `TMC_ADDR_U2_MODE:  next_r.u2.mode = I_BUS.wdata & `TMC_MODE_MASK;
        `TMC_ADDR_U2_LO:    next_r.u2.data[7:0] = I_BUS.wdata;
        `TMC_ADDR_U2_HI:    next_r.u2.data[15:8] = I_BUS.wdata;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************

  // whole block state
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************

  // pins, duty values and requests
  assign O_RDATA = r.rdata;
  assign O_UNIT1_PIN = (r.u1.mode[3:0] == TMC_M_SOFT) ? I_PORT1_LATCH : r.u1.pin;
  assign O_UNIT2_PIN = (r.u2.mode[3:0] == TMC_M_SOFT) ? I_PORT2_LATCH : r.u2.pin;
  assign O_DUTY1 = (r.u1.mode[3:2] == 2'h3) ? {r.u1.data[7:0], r.u1.mode[5:4]} : 10'h000;
  assign O_DUTY2 = (r.u2.mode[3:2] == 2'h3) ? {r.u2.data[7:0], r.u2.mode[5:4]} : 10'h000;
  assign O_OVF_IRQ = r.flags[`TMC_FLAG_OVF_BIT] & r.enables[`TMC_FLAG_OVF_BIT];
  assign O_UNIT2_IRQ = r.flags[`TMC_FLAG_U2_BIT] & r.enables[`TMC_FLAG_U2_BIT];
  assign O_CONV_START = r.conv_start;

endmodule

// ==== tb/tmc_core_model.sv ====
// processor core model acting as master on the plain register port
`timescale 1ns/1ps
module tmc_core (
  input  wire logic         i_clk,
  input  wire logic [7:0]   i_rdata,
  output tmc_pkg::tmc_bus_s o_bus
);
  import tmc_pkg::*;
  // idle bus from time zero
  initial o_bus = '0;
  // one-cycle write; address and data show their inverse once released
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    o_bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask
  // one-cycle read; data taken in the following cycle only
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    o_bus <= '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
    @(posedge i_clk);
    d = i_rdata;
  endtask
endmodule

// ==== tb/tmc_timer_chk.sv ====
// port assertions for the timer and match unit block
`timescale 1ns/1ps
`include "tmc_consts.svh"
module tmc_timer_chk (
  input wire logic              I_MCLK,
  input wire logic              I_RSTN,
  input wire tmc_pkg::tmc_bus_s I_BUS,
  input wire logic [7:0]        O_RDATA,
  input wire logic              I_EXT_CLK,
  input wire logic              I_CAP1_PIN,
  input wire logic              I_CAP2_PIN,
  input wire logic              I_PORT1_LATCH,
  input wire logic              I_PORT2_LATCH,
  input wire logic              I_CONV_ENABLE,
  input wire logic              O_UNIT1_PIN,
  input wire logic              O_UNIT2_PIN,
  input wire logic [9:0]        O_DUTY1,
  input wire logic [9:0]        O_DUTY2,
  input wire logic              O_OVF_IRQ,
  input wire logic              O_UNIT2_IRQ,
  input wire logic              O_CONV_START
);
  import tmc_pkg::*;
  logic [7:0] m1, m2, d1l, en;
  logic       wf;
  // write to the flag or enable register
  assign wf = I_BUS.wr && (I_BUS.addr <= 4'h1);
  // shadow of the software written mode, duty and enable registers
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      m1 <= 8'h00;
      m2 <= 8'h00;
      d1l <= 8'h00;
      en <= 8'h00;
    end else if (I_BUS.wr) begin
      case (I_BUS.addr)
        `TMC_ADDR_U1_MODE: m1 <= I_BUS.wdata & `TMC_MODE_MASK;
        `TMC_ADDR_U2_MODE: m2 <= I_BUS.wdata & `TMC_MODE_MASK;
        `TMC_ADDR_U1_LO: d1l <= I_BUS.wdata;
        `TMC_ADDR_ENABLES: en <= I_BUS.wdata;
        default: ;
      endcase
    end
  end
  // ********
  // assertions
  // ********
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RSTN);
  chk_rdata_idle: assert property (!$past(I_BUS.rd) |-> O_RDATA == 8'h00)
    else $error("read data not zero outside a read answer");
  chk_unmapped_zero: assert property ($past(I_BUS.rd && I_BUS.addr > 4'hc) |-> O_RDATA == 8'h00)
    else $error("unmapped read not zero");
  chk_mode_top_zero: assert property ($past(I_BUS.rd && (I_BUS.addr == 4'h7 ||
      I_BUS.addr == 4'ha)) |-> O_RDATA[7:6] == 2'b00)
    else $error("mode bits 7:6 not zero");
  chk_duty_value: assert property (!$past(I_BUS.wr) && !$past(I_BUS.wr, 2) |->
      O_DUTY1 == (m1[3:2] == 2'b11 ? {d1l, m1[5:4]} : 10'h000))
    else $error("duty value wrong");
  chk_ovf_gate: assert property (O_OVF_IRQ |-> en[1] || $past(en[1]))
    else $error("overflow request without enable");
  chk_ovf_sticky: assert property ($fell(O_OVF_IRQ) |-> $past(wf) || $past(wf, 2))
    else $error("overflow request dropped without software");
  chk_conv_cause: assert property (O_CONV_START |->
      $past(I_CONV_ENABLE) && $past(m2[3:0]) == 4'hb)
    else $error("conversion start without cause");
  chk_conv_pulse: assert property (O_CONV_START |=> !O_CONV_START)
    else $error("conversion start longer than one cycle");
  chk_latch_follow: assert property (m1[3:0] == 4'ha && $stable(m1) &&
      $stable(I_PORT1_LATCH) |-> O_UNIT1_PIN == I_PORT1_LATCH)
    else $error("pin not following port latch");
  chk_reserved_quiet: assert property (m1[3:0] inside {4'h0, 4'h1, 4'h3} &&
      $stable(m1) |-> !O_UNIT1_PIN)
    else $error("pin active in disabled mode");
  cov_conv: cover property (O_CONV_START);
  cov_ovf: cover property ($rose(O_OVF_IRQ));
  cov_duty: cover property (O_DUTY1 != 10'h000);
endmodule
bind tmc_timer tmc_timer_chk u_chk (.I_MCLK, .I_RSTN, .I_BUS, .O_RDATA, .I_EXT_CLK,
  .I_CAP1_PIN, .I_CAP2_PIN, .I_PORT1_LATCH, .I_PORT2_LATCH, .I_CONV_ENABLE, .O_UNIT1_PIN,
  .O_UNIT2_PIN, .O_DUTY1, .O_DUTY2, .O_OVF_IRQ, .O_UNIT2_IRQ, .O_CONV_START);

// ==== tb/tb.sv ====
// self-checking bench for the timer and match unit block
`timescale 1ns/1ps
`include "tmc_consts.svh"
module tb;
  import tmc_pkg::*;
  logic       clk, rstn, ext, cap2, lat1, conv, pin1, pin2, ovf, irq2, cs;
  logic [9:0] duty1, duty2;
  logic [7:0] rdata, v;
  tmc_bus_s   bus;
  int         error_cnt, comparisons, convs;
  logic [3:0] md[7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha};
  logic       e0[7] = '{0, 0, 0, 0, 0, 1, 1};
  logic       e1[7] = '{0, 0, 1, 0, 1, 0, 1};
  int         nr[4] = '{1, 1, 4, 16};
  tmc_timer dut (.I_MCLK(clk), .I_RSTN(rstn), .I_BUS(bus), .O_RDATA(rdata), .I_EXT_CLK(ext),
    .I_CAP1_PIN(1'b0), .I_CAP2_PIN(cap2), .I_PORT1_LATCH(lat1), .I_PORT2_LATCH(1'b0),
    .I_CONV_ENABLE(conv), .O_UNIT1_PIN(pin1), .O_UNIT2_PIN(pin2), .O_DUTY1(duty1),
    .O_DUTY2(duty2), .O_OVF_IRQ(ovf), .O_UNIT2_IRQ(irq2), .O_CONV_START(cs));
  tmc_core core (.i_clk(clk), .i_rdata(rdata), .o_bus(bus));
  // ********
  // helpers
  // ********
  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rng(input string n, input int lo, input int hi, input logic [9:0] g);
    comparisons++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      error_cnt++;
      $display("FAIL %s expected %0d..%0d seen %h", n, lo, hi, g);
    end
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] e, input string n);
    core.rd(a, v);
    chk(n, {2'b00, e}, {2'b00, v});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic ld(input logic [15:0] c);
    core.wr(`TMC_ADDR_CNT_HI, c[15:8]);
    core.wr(`TMC_ADDR_CNT_LO, c[7:0]);
  endtask
  // counts for n cycles with the given control, then stops
  task automatic run(input logic [7:0] c, input int n);
    core.wr(`TMC_ADDR_CNT_CTL, c);
    cyc(n);
    core.wr(`TMC_ADDR_CNT_CTL, 8'h00);
  endtask
  task automatic pulse();
    cap2 <= 1'b1;
    cyc(6);
    cap2 <= 1'b0;
    cyc(6);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // clock and counters
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (cs === 1'b1) convs++;
  // watchdog
  initial begin
    cyc(20000);
    error_cnt++;
    tally_and_finish();
  end
  // ********
  // tests
  // ********
  initial begin
    {rstn, ext, cap2, lat1, conv} = 5'b00000;
    cyc(16);
    rstn <= 1'b1;
    for (int a = 0; a < 14; a++) rc(a[3:0], 8'h00, "reset value");
    core.wr(`TMC_ADDR_U1_MODE, 8'hff);
    rc(`TMC_ADDR_U1_MODE, 8'h3f, "mode");
    core.wr(4'hd, 8'hff);
    rc(4'hd, 8'h00, "unmapped");
    core.wr(`TMC_ADDR_U1_MODE, 8'h00);
    core.wr(`TMC_ADDR_U1_LO, 8'h08);
    core.wr(`TMC_ADDR_U1_HI, 8'ha5);
    rc(`TMC_ADDR_U1_HI, 8'ha5, "data high");
    core.wr(`TMC_ADDR_U1_HI, 8'h00);
    ld(16'hfffe);
    run(8'h01, 40);
    rc(`TMC_ADDR_FLAGS, 8'h02, "flags");
    rc(`TMC_ADDR_CNT_HI, 8'h00, "wrap high");
    core.rd(`TMC_ADDR_CNT_LO, v);
    rng("wrap low", 7, 10, {2'b00, v});
    chk("masked irq", 10'h000, {9'h000, ovf});
    core.wr(`TMC_ADDR_ENABLES, 8'h02);
    cyc(20);
    chk("irq", 10'h001, {9'h000, ovf});
    core.wr(`TMC_ADDR_FLAGS, 8'h00);
    cyc(2);
    chk("cleared irq", 10'h000, {9'h000, ovf});
    ld(16'h1234);
    cyc(40);
    rc(`TMC_ADDR_CNT_LO, 8'h34, "held low");
    rc(`TMC_ADDR_CNT_HI, 8'h12, "held high");
    core.wr(`TMC_ADDR_CNT_CTL, 8'h80);
    ld(16'habcd);
    core.wr(`TMC_ADDR_CNT_HI, 8'h55);
    rc(`TMC_ADDR_CNT_LO, 8'hcd, "wide low");
    rc(`TMC_ADDR_CNT_HI, 8'hab, "wide buffer");
    core.wr(`TMC_ADDR_CNT_CTL, 8'h00);
    for (int p = 0; p < 4; p++) begin
      ld(16'h0000);
      run(8'h01 | 8'(p << 4), 256);
      core.rd(`TMC_ADDR_CNT_LO, v);
      rng("prescaled", (64 >> p) - 1, (64 >> p) + 2, {2'b00, v});
    end
    core.wr(`TMC_ADDR_COMP_CTL, 8'h08);
    ld(16'h0000);
    core.wr(`TMC_ADDR_CNT_CTL, 8'h03);
    repeat (10) pulse_ext();
    core.wr(`TMC_ADDR_CNT_CTL, 8'h00);
    core.rd(`TMC_ADDR_CNT_LO, v);
    rng("external", 9, 10, {2'b00, v});
    conv <= 1'b1;
    core.wr(`TMC_ADDR_U2_LO, 8'h10);
    core.wr(`TMC_ADDR_U2_MODE, 8'h0b);
    ld(16'h0000);
    core.wr(`TMC_ADDR_FLAGS, 8'h00);
    convs = 0;
    run(8'h01, 400);
    core.rd(`TMC_ADDR_CNT_LO, v);
    rng("period", 0, 16, {2'b00, v});
    rc(`TMC_ADDR_FLAGS, 8'h01, "event flags");
    rng("conversions", 3, 7, convs[9:0]);
    chk("pin2 special", 10'h000, {9'h000, pin2});
    core.wr(`TMC_ADDR_ENABLES, 8'h01);
    cyc(2);
    chk("unit irq", 10'h001, {9'h000, irq2});
    conv <= 1'b0;
    convs = 0;
    run(8'h01, 200);
    rng("no conversion", 0, 0, convs[9:0]);
    core.wr(`TMC_ADDR_U2_MODE, 8'h00);
    lat1 <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      ld(16'h0000);
      core.wr(`TMC_ADDR_U1_MODE, 8'h00);
      core.wr(`TMC_ADDR_U1_MODE, {4'h0, md[i]});
      cyc(3);
      chk("pin entry", {9'h000, e0[i]}, {9'h000, pin1});
      chk("duty off", 10'h000, duty1);
      run(8'h01, 60);
      chk("pin match", {9'h000, e1[i]}, {9'h000, pin1});
    end
    core.wr(`TMC_ADDR_U1_LO, 8'h5a);
    for (int c = 12; c < 16; c++) begin
      core.wr(`TMC_ADDR_U1_MODE, 8'he0 | 8'(c));
      cyc(2);
      chk("duty", {8'h5a, 2'b10}, duty1);
    end
    for (int c = 4; c < 8; c++) begin
      core.wr(`TMC_ADDR_U2_MODE, 8'h00);
      core.wr(`TMC_ADDR_U2_MODE, 8'(c));
      cyc(8);
      core.wr(`TMC_ADDR_FLAGS, 8'h00);
      repeat (nr[c - 4] - 1) pulse();
      rc(`TMC_ADDR_FLAGS, 8'h00, "early edges");
      cap2 <= 1'b1;
      cyc(8);
      rc(`TMC_ADDR_FLAGS, {7'h00, c != 4}, "rise");
      cap2 <= 1'b0;
      cyc(8);
      rc(`TMC_ADDR_FLAGS, 8'h01, "fall");
    end
    // second unit duty value from its low byte and mode bits 5-4
    core.wr(`TMC_ADDR_U2_LO, 8'h3c);
    core.wr(`TMC_ADDR_U2_MODE, 8'h1c);
    cyc(2);
    chk("duty2", {8'h3c, 2'b01}, duty2);
    core.wr(`TMC_ADDR_U2_MODE, 8'h00);
    cyc(2);
    chk("duty2 off", 10'h000, duty2);
    tally_and_finish();
  end
  // one external clock period of sixteen system cycles
  task automatic pulse_ext();
    ext <= 1'b1;
    cyc(8);
    ext <= 1'b0;
    cyc(8);
  endtask
endmodule
